// ===== bench/psd_mem_model.sv
`timescale 1ns/1ps
// memory behind the load path; answers at once or, in slow mode, after a few cycles
module psd_mem_model (
	input  wire logic         i_sys_clk,
	input  wire logic         i_srst,
	input  wire logic         i_slow,
	input  wire logic         i_mem_req,
	input  wire logic [31:0]  i_mem_addr,
	output logic              o_mem_gnt,
	output logic              o_mem_rvalid,
	output logic [127:0]      o_mem_rdata
);
	logic        busy;
	logic [1:0]  cnt;
	logic [31:0] held;

	// byte contents follow the address, so every offset is distinct
	function automatic logic [7:0] mem_byte(input logic [31:0] a);
		return a[7:0] ^ a[11:4] ^ 8'hC3;
	endfunction

	// slow mode holds grant and data back until the counter tops out
	assign o_mem_gnt = i_mem_req && !busy && (!i_slow || cnt == 2'h3);

	// data is inverted on every cycle after its valid one, so stale bytes match only on every other cycle
	always @(posedge i_sys_clk)
	begin
		o_mem_rvalid <= 1'h0;
		o_mem_rdata  <= ~o_mem_rdata;
		cnt          <= cnt + 2'h1;
		if (i_srst)
		begin
			busy        <= 1'h0;
			cnt         <= 2'h0;
			o_mem_rdata <= 128'h0;
		end
		else if (o_mem_gnt)
		begin
			busy <= 1'h1;
			held <= i_mem_addr;
			cnt  <= 2'h0;
		end
		else if (busy && (!i_slow || cnt == 2'h3))
		begin
			busy         <= 1'h0;
			o_mem_rvalid <= 1'h1;
			cnt          <= 2'h0;
			for (int i = 0; i < 16; i++)
				o_mem_rdata[8*i +: 8] <= mem_byte(held + i);
		end
	end
endmodule

// ===== bench/tb_packed_simd_integer_datapath.sv
`timescale 1ns/1ps
module tb_packed_simd_integer_datapath;
	logic                i_sys_clk = 1'h0;
	logic                i_srst    = 1'h1;
	logic                i_valid   = 1'h0;
	psd_pkg::psd_req_t   i_req     = '0;
	logic [127:0]        i_src_a   = '0;
	logic [127:0]        i_src_b   = '0;
	psd_pkg::psd_store_t i_store   = '0;
	logic                slow      = 1'h0;
	logic                gnt, rvalid, o_ready, o_valid, o_mem_req;
	logic [127:0]        rdata, o_result;
	logic [31:0]         o_mem_addr;
	logic [127:0]        exp_q[$];
	logic [7:0]          cnts[6] = '{8'h00, 8'h01, 8'h07, 8'h0F, 8'h10, 8'hFF};
	int                  errors = 0;
	int                  samples_checked = 0;
	int                  cycles = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;

	psd_datapath uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_valid(i_valid), .i_req(i_req),
		.i_src_a(i_src_a), .i_src_b(i_src_b), .i_store(i_store), .i_mem_gnt(gnt),
		.i_mem_rvalid(rvalid), .i_mem_rdata(rdata), .o_ready(o_ready), .o_valid(o_valid),
		.o_result(o_result), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr));

	psd_mem_model mem (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_slow(slow),
		.i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr), .o_mem_gnt(gnt),
		.o_mem_rvalid(rvalid), .o_mem_rdata(rdata));

	function automatic logic [7:0] mem_byte(input logic [31:0] a);
		return a[7:0] ^ a[11:4] ^ 8'hC3;
	endfunction

	function automatic logic [127:0] rnd();
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction

	// expected result of one operation, worked out lane by lane
	function automatic logic [127:0] ref_op(input psd_pkg::psd_op_t op, input logic w,
		input logic [7:0] imm, input logic [31:0] ad, input logic [127:0] a,
		input logic [127:0] b);
		logic [127:0] r;
		logic [255:0] blk;
		r = '0;
		for (int i = 0; i < 32; i++)
			blk[8*i +: 8] = mem_byte({ad[31:4], 4'h0} + i);
		for (int i = 0; i < 16; i++)
			case (op)
				psd_pkg::op_madd: if (i < 4) r[32*i +: 32] = $signed(a[32*i +: 16])
					* $signed(b[32*i +: 16]) + $signed(a[32*i+16 +: 16]) * $signed(b[32*i+16 +: 16]);
				psd_pkg::op_unsigned_dword_widening_multiply:
					if (i < 2) r[64*i +: 64] = a[64*i +: 32] * b[64*i +: 32];
				psd_pkg::op_quadword_add: if (i < 2) r[64*i +: 64] = a[64*i +: 64] + b[64*i +: 64];
				psd_pkg::op_quadword_subtract: if (i < 2) r[64*i +: 64] = a[64*i +: 64] - b[64*i +: 64];
				psd_pkg::op_bsll: r = (imm > 8'h0F) ? 128'h0 : a << (8 * imm);
				psd_pkg::op_bsrl: r = (imm > 8'h0F) ? 128'h0 : a >> (8 * imm);
				psd_pkg::op_avgb: r[8*i +: 8] = ({1'h0, a[8*i +: 8]} + b[8*i +: 8] + 9'h1) >> 1;
				psd_pkg::op_avgw: if (i < 8) r[16*i +: 16] = ({1'h0, a[16*i +: 16]} + b[16*i +: 16] + 17'h1) >> 1;
				psd_pkg::op_load: r = blk[8*ad[3:0] +: 128];
				default: r = '0;
			endcase
		if (!w && !(op inside {psd_pkg::op_bsll, psd_pkg::op_bsrl, psd_pkg::op_load}))
			r[127:64] = '0;
		return r;
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic issue(input psd_pkg::psd_op_t op, input logic w, input logic [7:0] imm,
		input logic [31:0] ad, input logic [127:0] a, input logic [127:0] b);
		i_valid = 1'h1;
		i_req   = '{op, w, imm, ad};
		i_src_a = a;
		i_src_b = b;
		exp_q.push_back(ref_op(op, w, imm, ad, a, b));
		while (o_ready !== 1'h1)
			@(posedge i_sys_clk) #1;
		@(posedge i_sys_clk) #1;
	endtask

	// results come back in issue order; the oldest note is compared
	// a result with no note behind it always counts as a mismatch, even if unknown
	always @(posedge i_sys_clk)
		if (o_valid === 1'h1)
		begin
			if (exp_q.size() > 0)
				check(o_result, exp_q.pop_front());
			else
				check(128'(exp_q.size()), 128'h1);
		end

	// hang guard, well above the expected run length
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles > 4000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		void'($urandom(32'h9A16562B));
		repeat (4) @(posedge i_sys_clk);
		#1;
		i_srst = 1'h0;
		// wrap in the low lane, nothing crosses into the high lane
		issue(psd_pkg::op_quadword_add, 1'h1, 8'h0, 32'h0, {64'h0, ~64'h0}, {64'h0, 64'h1});
		issue(psd_pkg::op_quadword_subtract, 1'h1, 8'h0, 32'h0, {64'h5, 64'h0}, {64'h0, 64'h1});
		foreach (cnts[i])
		begin
			issue(psd_pkg::op_bsll, 1'h0, cnts[i], 32'h0, rnd(), 128'h0);
			issue(psd_pkg::op_bsrl, 1'h1, cnts[i], 32'h0, rnd(), 128'h0);
		end
		// narrower overlapping store holds the load back
		i_store = '{1'h1, 32'h0000_0104, 5'h04};
		issue(psd_pkg::op_load, 1'h0, 8'h0, 32'h0000_0101, rnd(), rnd());
		i_valid = 1'h0;
		repeat (6)
		begin
			check(128'(o_mem_req), 128'h0);
			@(posedge i_sys_clk) #1;
		end
		i_store = '0;
		// every op, both forms, back to back
		for (int k = 0; k < 54; k++)
		begin
			slow = 1'($urandom);
			issue(psd_pkg::psd_op_t'(k % 9), 1'((k / 9) % 2), 8'($urandom_range(20, 0)),
				$urandom_range(4095, 0) & (k[1] ? 32'hFFF : 32'hFF0), rnd(), rnd());
		end
		i_valid = 1'h0;
		repeat (40) @(posedge i_sys_clk);
		check(128'(exp_q.size()), 128'h0);
		give_verdict();
	end
endmodule

// ===== design/psd_datapath.sv
// Operation
// - multiply-pair-add sums signed word product pairs into two dword results per 64-bit lane.
// - widening multiply takes low dword of each lane unsigned, full 64-bit product.
// - widening multiply has 64-bit and 128-bit forms, two independent lanes.
// - quadword add and subtract combine 64-bit elements lane by lane.
// - quadword results keep low 64 bits, wrap, same for signed and unsigned.
// - quadword 128-bit form has no carry between halves.
// - byte shifts move the 128-bit operand by immediate bytes, zero fill.
// - byte shift count above fifteen clears the whole destination.
// - aligned split-avoiding load returns exactly the 16 requested bytes.
// - misaligned load fetches 32 bytes from the address with low bits cleared.
// - misaligned load extracts 16 bytes starting at the requested address.
// - aligned load request count is implementation dependent.
// - load overlapping a pending store of another size waits for memory write.
// - packed average adds pairs plus one, shifts right, carry into top bit.
`timescale 1ns/1ps
module psd_datapath (
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_srst,
	input  wire logic                          i_valid,
	input  wire psd_pkg::psd_req_t             i_req,
	input  wire logic [psd_pkg::VEC_W-1:0]     i_src_a,
	input  wire logic [psd_pkg::VEC_W-1:0]     i_src_b,
	input  wire psd_pkg::psd_store_t           i_store,
	input  wire logic                          i_mem_gnt,
	input  wire logic                          i_mem_rvalid,
	input  wire logic [psd_pkg::VEC_W-1:0]     i_mem_rdata,
	output logic                               o_ready,
	output logic                               o_valid,
	output logic      [psd_pkg::VEC_W-1:0]     o_result,
	output logic                               o_mem_req,
	output logic      [psd_pkg::ADDR_W-1:0]    o_mem_addr
);

	typedef enum logic [1:0] {
		st_idle,
		st_stall,
		st_req,
		st_wait
	} psd_state_t;

	psd_state_t                   state;
	psd_state_t                   next_state;
	logic [psd_pkg::VEC_W-1:0]    result;
	logic [psd_pkg::VEC_W-1:0]    next_result;
	logic                         valid;
	logic                         next_valid;
	logic [psd_pkg::ADDR_W-1:0]   ld_addr;
	logic [psd_pkg::ADDR_W-1:0]   next_ld_addr;
	logic [psd_pkg::VEC_W-1:0]    lo_buf;
	logic [psd_pkg::VEC_W-1:0]    next_lo_buf;
	logic                         beat;
	logic                         next_beat;
	logic [psd_pkg::LANE_W-1:0]   lane_lo;
	logic [psd_pkg::LANE_W-1:0]   lane_hi;
	logic [psd_pkg::VEC_W-1:0]    alu_res;
	logic [psd_pkg::VEC_W-1:0]    extract;
	logic [2*psd_pkg::VEC_W-1:0]  pair;
	logic                         misaligned;
	logic                         conflict;
	logic                         take;

	// two identical lanes; the high one only matters in the 128-bit form
	// lanes combined apart
	psd_lane64 u_lane_lo (
		.i_op  (i_req.op),
		.i_a   (i_src_a[63:0]),
		.i_b   (i_src_b[63:0]),
		.o_res (lane_lo)
	);

	psd_lane64 u_lane_hi (
		.i_op  (i_req.op),
		.i_a   (i_src_a[127:64]),
		.i_b   (i_src_b[127:64]),
		.o_res (lane_hi)
	);

	// result select for the single-cycle operations
	always_comb
	begin
		alu_res = psd_pkg::RESULT_RST;
		case (i_req.op)
			psd_pkg::op_bsll:
				alu_res = i_src_a << {i_req.imm[3:0], 3'b000};
			psd_pkg::op_bsrl:
				alu_res = i_src_a >> {i_req.imm[3:0], 3'b000};
			// high lane kept only in the wide form
			// lanes computed apart, no carry joins them
			default:
				alu_res = {(i_req.wide ? lane_hi : 64'h0), lane_lo};
		endcase
		if ((i_req.op == psd_pkg::op_bsll || i_req.op == psd_pkg::op_bsrl)
			&& i_req.imm > psd_pkg::SHIFT_MAX)
			alu_res = psd_pkg::RESULT_RST;
	end

	// overlap with a store of another size
	assign conflict = i_store.valid && i_store.size != psd_pkg::LOAD_BYTES
		&& ({1'b0, i_store.addr} < {1'b0, ld_addr} + 33'(psd_pkg::LOAD_BYTES))
		&& ({1'b0, ld_addr} < {1'b0, i_store.addr} + 33'(i_store.size));

	assign misaligned = ld_addr[psd_pkg::ALIGN_LSB-1:0] != 4'h0;

	// pick 16 bytes out of the 32-byte block by the low address bits
	assign pair    = {i_mem_rdata, lo_buf} >> {ld_addr[3:0], 3'b000};
	assign extract = pair[psd_pkg::VEC_W-1:0];

	// operands are sampled only here, issue holds them until then
	assign take = i_valid && o_ready;

	// control and data next values
	always_comb
	begin
		next_state   = state;
		next_result  = result;
		next_valid   = 1'b0;
		next_ld_addr = ld_addr;
		next_lo_buf  = lo_buf;
		next_beat    = beat;
		case (state)
			st_idle:
			begin
				if (take && i_req.op == psd_pkg::op_load)
				begin
					next_ld_addr = i_req.addr;
					next_state   = st_stall;
				end
				else if (take)
				begin
					next_result = alu_res;
					next_valid  = 1'b1;
				end
			end
			// no memory read while an overlapping store of another size is pending
			st_stall:
			begin
				if (!conflict)
				begin
					next_beat  = 1'b0;
					next_state = st_req;
				end
			end
			st_req:
			begin
				if (i_mem_gnt)
					next_state = st_wait;
			end
			st_wait:
			begin
				if (i_mem_rvalid)
				begin
					// second granule for the misaligned case
					if (!beat && misaligned)
					begin
						next_lo_buf = i_mem_rdata;
						next_beat   = 1'b1;
						next_state  = st_req;
					end
					else
					begin
						// aligned case returns the granule as is
						// this build issues one request when aligned
						next_result = beat ? extract : i_mem_rdata;
						next_valid  = 1'b1;
						next_state  = st_idle;
					end
				end
			end
			default:
				next_state = st_idle;
		endcase
	end

	// state registers
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			state   <= st_idle;
			result  <= psd_pkg::RESULT_RST;
			valid   <= 1'b0;
			ld_addr <= psd_pkg::ADDR_RST;
			lo_buf  <= psd_pkg::RESULT_RST;
			beat    <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			result  <= next_result;
			valid   <= next_valid;
			ld_addr <= next_ld_addr;
			lo_buf  <= next_lo_buf;
			beat    <= next_beat;
		end
	end

	// outputs; address is built from registers only
	assign o_ready    = state == st_idle;
	assign o_valid    = valid;
	assign o_result   = result;
	assign o_mem_req  = state == st_req;
	// fetch address is the address with low four bits cleared, plus 16 on the second beat
	assign o_mem_addr = {ld_addr[31:4] + {27'h0, beat}, 4'h0};

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_take_op(psd_pkg::psd_op_t op);
		take && i_req.op == op;
	endsequence

	sequence s_ld_take;
		take && i_req.op == psd_pkg::op_load;
	endsequence

	sequence s_ld_busy;
		!o_ready && !o_valid;
	endsequence

	madd_pair_a: assert property (s_take_op(psd_pkg::op_madd) |=>
		o_valid && o_result[31:0] == 32'($signed($past(i_src_a[15:0]))
		* $signed($past(i_src_b[15:0])) + $signed($past(i_src_a[31:16]))
		* $signed($past(i_src_b[31:16]))))
		else $error("pair add low dword wrong");

	wmul_lane_a: assert property (
		s_take_op(psd_pkg::op_unsigned_dword_widening_multiply) |=>
		o_result[63:0] == {32'h0, $past(i_src_a[31:0])} * {32'h0, $past(i_src_b[31:0])})
		else $error("widening multiply low lane wrong");

	wmul_form_a: assert property (
		s_take_op(psd_pkg::op_unsigned_dword_widening_multiply) ##0 !i_req.wide
		|=> o_result[127:64] == 64'h0)
		else $error("narrow form high half not zero");

	qadd_hi_a: assert property (
		s_take_op(psd_pkg::op_quadword_add) ##0 i_req.wide |=>
		o_result[127:64] == $past(i_src_a[127:64]) + $past(i_src_b[127:64]))
		else $error("quadword add high lane wrong");

	qsub_lo_a: assert property (s_take_op(psd_pkg::op_quadword_subtract) |=>
		o_result[63:0] == $past(i_src_a[63:0]) - $past(i_src_b[63:0]))
		else $error("quadword subtract low lane wrong");

	shift_zero_a: assert property (
		take && (i_req.op == psd_pkg::op_bsll || i_req.op == psd_pkg::op_bsrl)
		&& i_req.imm > 8'h0F |=> o_valid && o_result == 128'h0)
		else $error("oversize shift not cleared");

	shift_left_a: assert property (
		s_take_op(psd_pkg::op_bsll) ##0 i_req.imm <= 8'h0F |=>
		o_result == $past(i_src_a) << (8 * $past(i_req.imm[3:0])))
		else $error("byte left shift wrong");

	avg_byte_a: assert property (s_take_op(psd_pkg::op_avgb) |=>
		{1'b0, o_result[7:0]} == ({1'b0, $past(i_src_a[7:0])}
		+ {1'b0, $past(i_src_b[7:0])} + 9'h001) >> 1)
		else $error("byte average wrong");

	load_busy_a: assert property (s_ld_take |=> s_ld_busy ##1 s_ld_busy)
		else $error("load did not hold the block busy");

	stall_hold_a: assert property (state == st_stall && conflict |=>
		!o_mem_req && state == st_stall)
		else $error("load read past a pending store");

	mem_align_a: assert property (o_mem_req |-> o_mem_addr[3:0] == 4'h0
		&& o_mem_addr == (ld_addr & 32'hFFFF_FFF0) + (beat ? 32'h10 : 32'h0))
		else $error("fetch address not block aligned");

	aligned_load_a: assert property (state == st_wait && i_mem_rvalid
		&& !misaligned |=> o_valid && o_result == $past(i_mem_rdata) && o_ready)
		else $error("aligned load data wrong");

endmodule

// ===== design/psd_lane64.sv
`timescale 1ns/1ps
module psd_lane64 (
	input  wire psd_pkg::psd_op_t          i_op,
	input  wire logic [psd_pkg::LANE_W-1:0] i_a,
	input  wire logic [psd_pkg::LANE_W-1:0] i_b,
	output logic      [psd_pkg::LANE_W-1:0] o_res
);

	// one 64-bit lane of arithmetic, purely combinational
	always_comb
	begin
		logic signed [31:0] p0;
		logic signed [31:0] p1;
		logic [8:0]         s9;
		logic [16:0]        s17;
		o_res = '0;
		p0    = '0;
		p1    = '0;
		s9    = '0;
		s17   = '0;
		case (i_op)
			psd_pkg::op_madd:
			begin
				for (int k = 0; k < 2; k++)
				begin
					p0 = $signed(i_a[32*k+:16]) * $signed(i_b[32*k+:16]);
					p1 = $signed(i_a[32*k+16+:16]) * $signed(i_b[32*k+16+:16]);
					o_res[32*k+:32] = p0 + p1; // 2 x 0x8000^2 wraps as in hardware
				end
			end
			psd_pkg::op_unsigned_dword_widening_multiply:
				o_res = {32'h0, i_a[31:0]} * {32'h0, i_b[31:0]};
			psd_pkg::op_quadword_add:
				o_res = i_a + i_b;
			psd_pkg::op_quadword_subtract:
				o_res = i_a - i_b;
			psd_pkg::op_avgb:
			begin
				for (int i = 0; i < 8; i++)
				begin
					s9 = {1'b0, i_a[8*i+:8]} + {1'b0, i_b[8*i+:8]} + 9'h001;
					o_res[8*i+:8] = s9[8:1]; // carry lands in the top bit
				end
			end
			psd_pkg::op_avgw:
			begin
				for (int i = 0; i < 4; i++)
				begin
					s17 = {1'b0, i_a[16*i+:16]} + {1'b0, i_b[16*i+:16]} + 17'h00001;
					o_res[16*i+:16] = s17[16:1];
				end
			end
			default:
				o_res = '0;
		endcase
	end

endmodule

// ===== pkg/psd_pkg.sv
package psd_pkg;

	// lane and vector geometry
	localparam int LANE_W = 64;
	localparam int VEC_W  = 128;
	localparam int ADDR_W = 32;

	// byte shift: counts above this clear the destination
	localparam logic [7:0] SHIFT_MAX = 8'h0F;

	// split-avoiding load: fetch granule and delivered size in bytes
	localparam logic [4:0] LOAD_BYTES = 5'h10;
	localparam int         ALIGN_LSB  = 4;

	// reset values
	localparam logic [VEC_W-1:0]  RESULT_RST = 128'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 32'h0;

	// operation select
	typedef enum logic [3:0] {
		op_madd,
		op_unsigned_dword_widening_multiply,
		op_quadword_add,
		op_quadword_subtract,
		op_bsll,
		op_bsrl,
		op_avgb,
		op_avgw,
		op_load
	} psd_op_t;

	// one issued operation, presented with its operands
	typedef struct packed {
		psd_op_t           op;
		logic              wide;
		logic [7:0]        imm;
		logic [ADDR_W-1:0] addr;
	} psd_req_t;

	// oldest pending store not yet written to memory
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [4:0]        size;
	} psd_store_t;

endpackage
